// ===== csbk_pkg.sv
// constants, types and register map of the configuration capability bank
package csbk_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MSI_UADDR = 8'h94;
    localparam logic [7:0] OFS_MSI_DATA  = 8'h98;
    localparam logic [7:0] OFS_VPD_CTRL  = 8'h9c;
    localparam logic [7:0] OFS_PRODUCT_DATA_DATA  = 8'ha0;
    localparam logic [7:0] OFS_VND_CAP   = 8'ha4;
    localparam logic [7:0] OFS_TCW0      = 8'ha8;
    localparam logic [7:0] OFS_TCW1      = 8'hac;
    localparam logic [7:0] OFS_TIMERS    = 8'hb0;
    localparam logic [7:0] OFS_DRV_MODE  = 8'hb4;
    localparam logic [7:0] OFS_PM_PARAM  = 8'hb8;
    // capability header constants
    localparam logic [7:0]  VPD_CAP_ID   = 8'h03;
    localparam logic [7:0]  VPD_NEXT     = 8'ha4;
    localparam logic [7:0]  VND_CAP_ID   = 8'h09;
    localparam logic [7:0]  VND_NEXT     = 8'he0;
    localparam logic [15:0] VND_LENGTH   = 16'h0028;
    localparam logic        MSI64_CAP    = 1'b1;
    // values after reset
    localparam logic [31:0] MSI_UADDR_RST = 32'h00000000;
    localparam logic [15:0] MSI_DATA_RST  = 16'h0000;
    localparam logic [31:0] PRODUCT_DATA_DATA_RST  = 32'h00000000;
    localparam logic [4:0]  VPD_IDX_RST   = 5'h00;
    localparam logic [31:0] TCW0_RST      = 32'h04001060;
    localparam logic [31:0] TCW1_RST      = 32'h04000271;
    localparam logic [11:0] RPL_RST       = 12'h000;
    localparam logic [13:0] ACK_RST       = 14'h0000;
    localparam logic [3:0]  DRV_RST       = 4'h0;
    localparam logic [23:0] DRV_RSV_RST   = 24'h000000;
    // field positions
    localparam int VPD_GO_BIT  = 16;
    localparam int VPD_DIR_BIT = 17;
    localparam int VPD_IDX_LSB = 18;
    localparam int RPL_EN_BIT  = 12;
    localparam int ACK_LSB     = 16;
    localparam int ACK_EN_BIT  = 30;
    localparam int DRV1_LSB    = 4;

    typedef enum logic [3:0] {
        DRV_RS232    = 4'h0,
        DRV_RS422    = 4'h1,
        DRV_RS485_4W = 4'hb,
        DRV_RS485_2W = 4'hf
    } csbk_drv_mode_type;

    typedef enum logic {
        VPD_IDLE = 1'b0,
        VPD_BUSY = 1'b1
    } csbk_vpd_state_type;

    typedef struct packed {
        logic        rpl_en;
        logic [11:0] rpl;
        logic        ack_en;
        logic [13:0] ack;
        logic [3:0]  drv0;
        logic [3:0]  drv1;
        logic [5:0]  pm;
    } csbk_autoload_type;

    typedef struct packed {
        logic        write;
        logic [4:0]  index;
        logic [31:0] wdata;
    } csbk_vpd_req_type;
endpackage : csbk_pkg

// ===== csbk_bank.sv
// configuration capability register bank with product-data handshake
`timescale 1ns/1ns
module csbk_bank #(
    parameter logic [11:0] RPL_BUILTIN = 12'h0ff,
    parameter logic [13:0] ACK_BUILTIN = 14'h0040,
    parameter logic [5:0]  PM_RST      = 6'h00
) (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // product-data table engine
    output logic                            vpd_req_valid,
    output csbk_pkg::csbk_vpd_req_type      vpd_req,
    input  wire logic                       vpd_done,
    input  wire logic [31:0]                vpd_rdata,
    // eeprom autoload
    input  wire logic                       autoload_valid,
    input  wire csbk_pkg::csbk_autoload_type autoload,
    // settings to the rest of the bridge
    output logic                            msi_addr64_capable,
    output logic      [31:0]                msi_upper_eff,
    output logic      [15:0]                msi_data,
    output logic      [11:0]                replay_timeout_eff,
    output logic      [13:0]                ack_latency_eff,
    output csbk_pkg::csbk_drv_mode_type     drv_mode0,
    output csbk_pkg::csbk_drv_mode_type     drv_mode1,
    output logic      [5:0]                 pm_param,
    output logic      [31:0]                test_word0,
    output logic      [31:0]                test_word1
);
    generate
        if (PM_RST > 6'h3f || RPL_BUILTIN == 12'h000) begin : g_bad
            $error("csbk_bank: unusable parameter values");
        end
    endgenerate

    csbk_pkg::csbk_vpd_state_type vpd_state_q;
    logic        vpd_dir_q;
    logic [4:0]  vpd_idx_q;
    logic [31:0] product_data_data_q;
    logic [31:0] msi_uaddr_q;
    logic [15:0] msi_data_q;
    logic [31:0] tcw0_q;
    logic [31:0] tcw1_q;
    logic [11:0] rpl_q;
    logic        rpl_en_q;
    logic [13:0] ack_q;
    logic        ack_en_q;
    logic [3:0]  drv0_q;
    logic [3:0]  drv1_q;
    logic [23:0] drv_rsv_q;
    logic [5:0]  pm_q;
    logic [31:0] rd_d;
    logic        err_d;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        wr_en;
    logic [31:0] wmask;

    // byte-lane mask from the write strobes
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    // zero-wait slave: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign wr_en   = psel & penable & pwrite & ~pslverr_q;

    always_comb begin
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        unique case (paddr)
            csbk_pkg::OFS_MSI_UADDR: rd_d = msi_uaddr_q;
            csbk_pkg::OFS_MSI_DATA:  rd_d = {16'h0000, msi_data_q};
            csbk_pkg::OFS_VPD_CTRL:
                rd_d = {9'h000, vpd_idx_q, vpd_dir_q,
                        vpd_state_q == csbk_pkg::VPD_BUSY,
                        csbk_pkg::VPD_NEXT,
                        csbk_pkg::VPD_CAP_ID};
            csbk_pkg::OFS_PRODUCT_DATA_DATA:  rd_d = product_data_data_q;
            csbk_pkg::OFS_VND_CAP:
                rd_d = {csbk_pkg::VND_LENGTH,
                        csbk_pkg::VND_NEXT,
                        csbk_pkg::VND_CAP_ID};
            csbk_pkg::OFS_TCW0:      rd_d = tcw0_q;
            csbk_pkg::OFS_TCW1:      rd_d = tcw1_q;
            csbk_pkg::OFS_TIMERS:
                rd_d = {1'b0, ack_en_q, ack_q, 3'h0, rpl_en_q, rpl_q};
            csbk_pkg::OFS_DRV_MODE:  rd_d = {drv_rsv_q, drv1_q, drv0_q};
            csbk_pkg::OFS_PM_PARAM:  rd_d = {26'h0000000, pm_q};
            default:                 err_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_d;
            pslverr_q <= err_d;
        end
    end

    // message interrupt tail
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msi_uaddr_q <= csbk_pkg::MSI_UADDR_RST;
            msi_data_q  <= csbk_pkg::MSI_DATA_RST;
        end else if (wr_en && paddr == csbk_pkg::OFS_MSI_UADDR) begin
            msi_uaddr_q <= merge(msi_uaddr_q, pwdata, wmask);
        end else if (wr_en && paddr == csbk_pkg::OFS_MSI_DATA) begin
            msi_data_q <= 16'((msi_data_q & ~wmask[15:0])
                              | (pwdata[15:0] & wmask[15:0]));
        end
    end

    assign msi_addr64_capable = csbk_pkg::MSI64_CAP;
    assign msi_upper_eff = msi_addr64_capable ? msi_uaddr_q
                                              : 32'h00000000;
    assign msi_data = msi_data_q;

    // product-data handshake; control writes are ignored while busy
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vpd_state_q <= csbk_pkg::VPD_IDLE;
            vpd_dir_q   <= 1'b0;
            vpd_idx_q   <= csbk_pkg::VPD_IDX_RST;
        end else begin
            unique case (vpd_state_q)
                csbk_pkg::VPD_IDLE: begin
                    if (wr_en && paddr == csbk_pkg::OFS_VPD_CTRL
                        && pstrb[2]) begin
                        vpd_dir_q <= pwdata[csbk_pkg::VPD_DIR_BIT];
                        vpd_idx_q <= pwdata[csbk_pkg::VPD_IDX_LSB +: 5];
                        if (pwdata[csbk_pkg::VPD_GO_BIT]) begin
                            vpd_state_q <= csbk_pkg::VPD_BUSY;
                        end
                    end
                end
                csbk_pkg::VPD_BUSY: begin
                    if (vpd_done) begin
                        vpd_state_q <= csbk_pkg::VPD_IDLE;
                    end
                end
            endcase
        end
    end

    // data word: fetched on read completion, written by software when idle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            product_data_data_q <= csbk_pkg::PRODUCT_DATA_DATA_RST;
        end else if (vpd_state_q == csbk_pkg::VPD_BUSY) begin
            if (vpd_done && !vpd_dir_q) begin
                product_data_data_q <= vpd_rdata;
            end
        end else if (wr_en && paddr == csbk_pkg::OFS_PRODUCT_DATA_DATA) begin
            product_data_data_q <= merge(product_data_data_q, pwdata, wmask);
        end
    end

    assign vpd_req_valid = (vpd_state_q == csbk_pkg::VPD_BUSY);
    assign vpd_req.write = vpd_dir_q;
    assign vpd_req.index = vpd_idx_q;
    assign vpd_req.wdata = product_data_data_q;

    // test control words
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tcw0_q <= csbk_pkg::TCW0_RST;
            tcw1_q <= csbk_pkg::TCW1_RST;
        end else if (wr_en && paddr == csbk_pkg::OFS_TCW0) begin
            tcw0_q <= merge(tcw0_q, pwdata, wmask);
        end else if (wr_en && paddr == csbk_pkg::OFS_TCW1) begin
            tcw1_q <= merge(tcw1_q, pwdata, wmask);
        end
    end

    assign test_word0 = tcw0_q;
    assign test_word1 = tcw1_q;

    // link timer overrides; autoload beats a software write in one cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rpl_q    <= csbk_pkg::RPL_RST;
            rpl_en_q <= 1'b0;
            ack_q    <= csbk_pkg::ACK_RST;
            ack_en_q <= 1'b0;
        end else if (autoload_valid) begin
            rpl_q    <= autoload.rpl;
            rpl_en_q <= autoload.rpl_en;
            ack_q    <= autoload.ack;
            ack_en_q <= autoload.ack_en;
        end else if (wr_en && paddr == csbk_pkg::OFS_TIMERS) begin
            if (pstrb[0]) begin
                rpl_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                rpl_q[11:8] <= pwdata[11:8];
                rpl_en_q    <= pwdata[csbk_pkg::RPL_EN_BIT];
            end
            if (pstrb[2]) begin
                ack_q[7:0] <= pwdata[23:16];
            end
            if (pstrb[3]) begin
                ack_q[13:8] <= pwdata[29:24];
                ack_en_q    <= pwdata[csbk_pkg::ACK_EN_BIT];
            end
        end
    end

    assign replay_timeout_eff = rpl_en_q ? rpl_q : RPL_BUILTIN;
    assign ack_latency_eff    = ack_en_q ? ack_q : ACK_BUILTIN;

    // transceiver modes and power parameter
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drv0_q    <= csbk_pkg::DRV_RST;
            drv1_q    <= csbk_pkg::DRV_RST;
            drv_rsv_q <= csbk_pkg::DRV_RSV_RST;
            pm_q      <= PM_RST;
        end else if (autoload_valid) begin
            drv0_q <= autoload.drv0;
            drv1_q <= autoload.drv1;
            pm_q   <= autoload.pm;
        end else if (wr_en && paddr == csbk_pkg::OFS_DRV_MODE) begin
            if (pstrb[0]) begin
                drv0_q <= pwdata[3:0];
                drv1_q <= pwdata[csbk_pkg::DRV1_LSB +: 4];
            end
            drv_rsv_q <= 24'(merge({8'h00, drv_rsv_q},
                                   {8'h00, pwdata[31:8]},
                                   {8'h00, wmask[31:8]}));
        end else if (wr_en && paddr == csbk_pkg::OFS_PM_PARAM
                     && pstrb[0]) begin
            pm_q <= pwdata[5:0];
        end
    end

    assign drv_mode0 = csbk_pkg::csbk_drv_mode_type'(drv0_q);
    assign drv_mode1 = csbk_pkg::csbk_drv_mode_type'(drv1_q);
    assign pm_param  = pm_q;

    // checks next to the logic
    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite;

    property p_upper_gate;
        @(posedge clk_sys) disable iff (!rstn)
        wr_en && paddr == csbk_pkg::OFS_MSI_UADDR && pstrb == 4'hf
        |=> msi_upper_eff == $past(pwdata);
    endproperty
    a_upper_gate: assert property (p_upper_gate)
        else $error("upper address gating wrong");

    property p_cap64;
        @(posedge clk_sys) disable iff (!rstn)
        msi_addr64_capable == 1'b1;
    endproperty
    a_cap64: assert property (p_cap64)
        else $error("64-bit capability not reported");

    property p_vpd_hdr;
        @(posedge clk_sys) disable iff (!rstn)
        rd_setup && paddr == csbk_pkg::OFS_VPD_CTRL
        |=> prdata[15:0] == 16'ha403;
    endproperty
    a_vpd_hdr: assert property (p_vpd_hdr)
        else $error("product-data header wrong");

    property p_vnd_hdr;
        @(posedge clk_sys) disable iff (!rstn)
        rd_setup && paddr == csbk_pkg::OFS_VND_CAP
        |=> prdata == 32'h0028e009;
    endproperty
    a_vnd_hdr: assert property (p_vnd_hdr)
        else $error("vendor header wrong");

    property p_go_clear;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && vpd_done |=> !vpd_req_valid;
    endproperty
    a_go_clear: assert property (p_go_clear)
        else $error("go bit not cleared on completion");

    property p_go_hold;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && !vpd_done |=> vpd_req_valid && $stable(vpd_req);
    endproperty
    a_go_hold: assert property (p_go_hold)
        else $error("request dropped or changed while busy");

    property p_fetch;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && vpd_done && !vpd_req.write
        |=> product_data_data_q == $past(vpd_rdata);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetched word not latched");

    property p_wr_keep;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && vpd_done && vpd_req.write
        |=> $stable(product_data_data_q);
    endproperty
    a_wr_keep: assert property (p_wr_keep)
        else $error("data word changed by table write");

    property p_replay;
        @(posedge clk_sys) disable iff (!rstn)
        replay_timeout_eff == (rpl_en_q ? rpl_q : RPL_BUILTIN);
    endproperty
    a_replay: assert property (p_replay)
        else $error("replay timeout selection wrong");

    property p_ack;
        @(posedge clk_sys) disable iff (!rstn)
        !ack_en_q |-> ack_latency_eff == ACK_BUILTIN;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack latency selection wrong");

    property p_cv_read;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && vpd_done && !vpd_req.write;
    endproperty
    c_cv_read: cover property (p_cv_read);

    property p_cv_write;
        @(posedge clk_sys) disable iff (!rstn)
        vpd_req_valid && vpd_done && vpd_req.write;
    endproperty
    c_cv_write: cover property (p_cv_write);

    property p_cv_err;
        @(posedge clk_sys) disable iff (!rstn)
        psel && penable && pslverr;
    endproperty
    c_cv_err: cover property (p_cv_err);
endmodule : csbk_bank

// ===== csbk_bank_fix_note_unused.sv
// reserved for later bank extensions; holds no logic

// ===== csbk_table_model.sv
// behavioural product-data table engine facing the bank
`timescale 1ns/1ns
module csbk_table_model (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // request from the bank
    input  wire logic                       req_valid,
    input  wire csbk_pkg::csbk_vpd_req_type req,
    input  wire logic [7:0]                 delay,
    // answer to the bank
    output logic                            done,
    output logic [31:0]                     rdata
);
    logic [31:0] mem_q [32];
    int          cnt;

    initial begin
        for (int i = 0; i < 32; i++) begin
            mem_q[i] = 32'h5eed0000 + i * 32'h00000103;
        end
    end

    // read data changes outside the done cycle so a late latch is caught
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt = 0;
            done <= 1'b0;
            rdata <= 32'h5a5a5a5a;
        end else begin
            done <= 1'b0;
            rdata <= ~rdata;
            if (req_valid && !done) begin
                if (cnt >= int'(delay)) begin
                    cnt = 0;
                    done <= 1'b1;
                    rdata <= mem_q[req.index];
                    if (req.write) begin
                        mem_q[req.index] <= req.wdata;
                    end
                end else begin
                    cnt++;
                end
            end
        end
    end
endmodule : csbk_table_model

// ===== tb.sv
// self-checking bench for the configuration capability bank
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] RPL_B = 12'h0ff;
    localparam logic [13:0] ACK_B = 14'h0040;
    localparam logic [5:0]  PM_R  = 6'h15;
    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, tbl_delay;
    logic [31:0] pwdata, prdata, vpd_rdata, msi_upper_eff;
    logic [31:0] test_word0, test_word1;
    logic [3:0]  pstrb;
    logic        vpd_req_valid, vpd_done, autoload_valid;
    logic        msi_addr64_capable;
    logic [15:0] msi_data;
    logic [11:0] replay_timeout_eff;
    logic [13:0] ack_latency_eff;
    logic [5:0]  pm_param;
    int          err_total, n_checks;
    csbk_pkg::csbk_vpd_req_type  vpd_req;
    csbk_pkg::csbk_autoload_type autoload;
    csbk_pkg::csbk_drv_mode_type drv_mode0, drv_mode1;

    csbk_bank #(.RPL_BUILTIN(RPL_B), .ACK_BUILTIN(ACK_B), .PM_RST(PM_R))
    csbk_bank_inst (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .vpd_req_valid,
        .vpd_req, .vpd_done, .vpd_rdata, .autoload_valid, .autoload,
        .msi_addr64_capable, .msi_upper_eff, .msi_data,
        .replay_timeout_eff, .ack_latency_eff, .drv_mode0, .drv_mode1,
        .pm_param, .test_word0, .test_word1);

    csbk_table_model csbk_table_model_inst (.clk_sys, .rstn,
        .req_valid(vpd_req_valid), .req(vpd_req), .delay(tbl_delay),
        .done(vpd_done), .rdata(vpd_rdata));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk($sformatf("reg %h", a), q, x);
    endtask : rdc

    task automatic t_reset();
        logic [7:0]  ra [10] = '{8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4,
                                 8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8};
        logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0000a403, 32'h0,
            32'h0028e009, 32'h04001060, 32'h04000271, 32'h0, 32'h0,
            {26'h0, PM_R}};
        for (int i = 0; i < 10; i++) begin
            rdc(ra[i], rv[i]);
        end
        chk("addr64 cap", msi_addr64_capable, 1'b1);
        chk("rpl eff", replay_timeout_eff, RPL_B);
        chk("ack eff", ack_latency_eff, ACK_B);
    endtask : t_reset

    task automatic t_basic();
        logic [31:0] q;
        logic        e;
        wr(8'h94, 32'hfedc1234);
        wr(8'h98, 32'hffffffff);
        wr(8'ha4, 32'hffffffff);
        wr(8'ha8, 32'h13572468);
        @(negedge clk_sys);
        chk("upper addr", msi_upper_eff, 32'hfedc1234);
        chk("msg data", msi_data, 16'hffff);
        chk("test word", test_word0, 32'h13572468);
        rdc(8'h98, 32'h0000ffff);
        rdc(8'ha4, 32'h0028e009);
        apb(1'b0, 8'hc0, 32'h0, q, e);
        chk("unmapped err", e, 1'b1);
        apb(1'b1, 8'h95, 32'h0, q, e);
        chk("unaligned err", e, 1'b1);
    endtask : t_basic

    task automatic t_timers();
        wr(8'hb0, 32'hffffffff);
        rdc(8'hb0, 32'h7fff1fff);
        wr(8'hb0, 32'h2abc0abc);
        @(negedge clk_sys);
        chk("rpl builtin", replay_timeout_eff, RPL_B);
        chk("ack builtin", ack_latency_eff, ACK_B);
        wr(8'hb0, 32'h6abc1abc);
        @(negedge clk_sys);
        chk("rpl user", replay_timeout_eff, 12'habc);
        chk("ack user", ack_latency_eff, 14'h2abc);
        // only byte lane 0 may change
        pstrb <= 4'h1;
        wr(8'hb0, 32'h00000000);
        pstrb <= 4'hf;
        rdc(8'hb0, 32'h6abc1a00);
    endtask : t_timers

    task automatic t_drive();
        logic [3:0] m [4] = '{4'h0, 4'h1, 4'hb, 4'hf};
        for (int i = 0; i < 4; i++) begin
            wr(8'hb4, {24'h5a5a5a, m[3-i], m[i]});
            @(negedge clk_sys);
            chk("port0 mode", drv_mode0, m[i]);
            chk("port1 mode", drv_mode1, m[3-i]);
            rdc(8'hb4, {24'h5a5a5a, m[3-i], m[i]});
        end
        wr(8'hb8, 32'hffffffff);
        rdc(8'hb8, 32'h0000003f);
        chk("pm param", pm_param, 6'h3f);
    endtask : t_drive

    // start one table access and poll until the go bit falls
    task automatic go(input logic [4:0] idx, input logic dir);
        logic [31:0] q;
        logic        e;
        int          n;
        wr(8'h9c, {9'h0, idx, dir, 1'b1, 16'h0});
        @(negedge clk_sys);
        chk("req valid", vpd_req_valid, 1'b1);
        chk("req index", vpd_req.index, idx);
        chk("req write", vpd_req.write, dir);
        n = 0;
        do begin
            apb(1'b0, 8'h9c, 32'h0, q, e);
            n++;
        end while (q[16] !== 1'b0 && n < 100);
        chk("ctrl after", q[22:16], {idx, dir, 1'b0});
        chk("req idle", vpd_req_valid, 1'b0);
    endtask : go

    task automatic t_table(input logic [7:0] dly, input logic [4:0] idx,
                           input logic [31:0] d);
        tbl_delay <= dly;
        wr(8'ha0, d);
        @(negedge clk_sys);
        chk("req data", vpd_req.wdata, d);
        go(idx, 1'b1);
        go(idx ^ 5'h01, 1'b0);
        rdc(8'ha0, 32'h5eed0000 + 32'(idx ^ 5'h01) * 32'h103);
        go(idx, 1'b0);
        rdc(8'ha0, d);
    endtask : t_table

    task automatic t_autoload();
        @(posedge clk_sys);
        autoload <= '{rpl_en: 1'b1, rpl: 12'h123, ack_en: 1'b1,
            ack: 14'h2bcd, drv0: 4'hb, drv1: 4'hf, pm: 6'h2a};
        autoload_valid <= 1'b1;
        @(posedge clk_sys);
        autoload_valid <= 1'b0;
        @(negedge clk_sys);
        chk("al rpl", replay_timeout_eff, 12'h123);
        chk("al ack", ack_latency_eff, 14'h2bcd);
        rdc(8'hb0, 32'h6bcd1123);
        rdc(8'hb4, 32'h5a5a5afb);
        rdc(8'hb8, 32'h0000002a);
    endtask : t_autoload

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        autoload_valid = 1'b0;
        autoload = '0;
        tbl_delay = 8'h00;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_basic();
        t_timers();
        t_drive();
        t_table(8'h00, 5'h03, 32'h1234abcd);
        t_table(8'h14, 5'h1f, 32'h89abcdef);
        t_autoload();
        // a second reset must undo autoloaded values as well
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        tally_and_finish();
    end

    // the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : tb
